//--- rtl/sbst_tap.sv
// Boundary-scan test access port of the burst SRAM, sampled on the system clock.
`timescale 1ns/1ns
// Summary of operation
// [R1] - Sample on rising, drive on falling edge.
// [R2] - TMS steers controller, reads one unconnected.
// [R3] - Held instruction chooses the scan register.
// [R4] - Only one register in the path.
// [R5] - Data enters MSB, leaves from LSB.
// [R6] - TDO driven only while shifting.
// [R7] - Five TMS-high edges reach reset state.
// [R8] - Test reset leaves memory operation alone.
// [R9] - Power-up reset leaves TDO high impedance.
// [R10] - Three-bit instruction register loaded serially.
// [R11] - Reset loads identification instruction.
// [R12] - Capture-IR loads 01 into low bits.
// [R13] - Bypass is one single-bit stage.
// [R14] - Bypass instruction clears bypass bit.
// [R15] - Boundary register has 107 bits.
// [R16] - Capture ring in Capture-DR, shift in Shift-DR.
// [R17] - EXTEST, sample, sample-Z capture the ring.
// [R18] - Identification loads fixed 32-bit code.
// [R19] - All-zero instruction acts like sample.
// [R20] - Sample-Z forces memory outputs high impedance.
// [R21] - Bypass bit forms path under bypass.
// [R22] - Standard sixteen-state controller on TMS.
module sbst_tap
  import sbst_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic [SBST_BSR_W-1:0] ring_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic mem_out_hiz_o,
  output logic test_reset_o
);

  // All state of the port outside the synchroniser lives in one record, registered as a whole.
  typedef struct packed {
    sbst_state_t st;
    logic [SBST_IR_W-1:0] ir_shift;
    logic [SBST_IR_W-1:0] ir;
    logic bypass;
    logic [SBST_BSR_W-1:0] bsr;
    logic [SBST_ID_W-1:0] id;
    logic tdo;
    logic tdo_oe;
    logic hiz;
    logic trst;
  } sbst_tap_t;

  // Which data register a held instruction routes between TDI and TDO.
  typedef enum logic [2:0] {
    SBST_PATH_BSR = 3'h1,
    SBST_PATH_ID = 3'h2,
    SBST_PATH_BYP = 3'h4
  } sbst_path_t;

  sbst_tap_t q, d;
  sbst_path_t path;
  logic tck_rise;
  logic tck_fall;
  logic tms_s;
  logic tdi_s;

  // The test pins come from another domain and pass two flops first.
  // A test-clock phase shorter than one system clock can be lost, so the test clock
  // must stay well below half the system clock.
  sbst_sync u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(en_i),
    .tck_i(tck_i),
    .tms_i(tms_i),
    .tdi_i(tdi_i),
    .rise_o(tck_rise),
    .fall_o(tck_fall),
    .tms_o(tms_s),
    .tdi_o(tdi_s)
  );

  // Next controller state for the TMS level seen at a rising test-clock edge.
  function automatic sbst_state_t sbst_next(input sbst_state_t s, input logic tms);
    sbst_state_t n;
    n = SBST_TLR;
    unique case (s)
      SBST_TLR: begin
        n = tms ? SBST_TLR : SBST_RTI;
      end
      SBST_RTI: begin
        n = tms ? SBST_SEL_DR : SBST_RTI;
      end
      SBST_SEL_DR: begin
        n = tms ? SBST_SEL_IR : SBST_CAP_DR;
      end
      SBST_CAP_DR: begin
        n = tms ? SBST_EX1_DR : SBST_SHF_DR;
      end
      SBST_SHF_DR: begin
        n = tms ? SBST_EX1_DR : SBST_SHF_DR;
      end
      SBST_EX1_DR: begin
        n = tms ? SBST_UPD_DR : SBST_PAU_DR;
      end
      SBST_PAU_DR: begin
        n = tms ? SBST_EX2_DR : SBST_PAU_DR;
      end
      SBST_EX2_DR: begin
        n = tms ? SBST_UPD_DR : SBST_SHF_DR;
      end
      SBST_UPD_DR: begin
        n = tms ? SBST_SEL_DR : SBST_RTI;
      end
      SBST_SEL_IR: begin
        n = tms ? SBST_TLR : SBST_CAP_IR;
      end
      SBST_CAP_IR: begin
        n = tms ? SBST_EX1_IR : SBST_SHF_IR;
      end
      SBST_SHF_IR: begin
        n = tms ? SBST_EX1_IR : SBST_SHF_IR;
      end
      SBST_EX1_IR: begin
        n = tms ? SBST_UPD_IR : SBST_PAU_IR;
      end
      SBST_PAU_IR: begin
        n = tms ? SBST_EX2_IR : SBST_PAU_IR;
      end
      SBST_EX2_IR: begin
        n = tms ? SBST_UPD_IR : SBST_SHF_IR;
      end
      SBST_UPD_IR: begin
        n = tms ? SBST_SEL_DR : SBST_RTI;
      end
      default: begin
        n = SBST_TLR;
      end
    endcase
    return n;
  endfunction

  // Reserved codes fall to the bypass bit so that a stray code never breaks the chain.
  function automatic sbst_path_t sbst_path(input logic [SBST_IR_W-1:0] ir);
    sbst_path_t p;
    p = SBST_PATH_BYP;
    unique case (ir)
      SBST_INS_EXTEST: begin
        p = SBST_PATH_BSR; // [R19]
      end
      SBST_INS_SAMPLE: begin
        p = SBST_PATH_BSR; // [R17]
      end
      SBST_INS_SAMPLE_Z: begin
        p = SBST_PATH_BSR; // [R17] [R20]
      end
      SBST_INS_IDCODE: begin
        p = SBST_PATH_ID; // [R18]
      end
      default: begin
        p = SBST_PATH_BYP; // [R21]
      end
    endcase
    return p;
  endfunction

  // Only the two shift states drive TDO; everywhere else the pin floats.
  function automatic logic sbst_is_shift(input sbst_state_t s);
    return (s == SBST_SHF_DR) || (s == SBST_SHF_IR);
  endfunction

  // Only sample-Z floats the memory outputs; the all-zero code leaves them running.
  function automatic logic sbst_floats_memory(input logic [SBST_IR_W-1:0] ir);
    return ir == SBST_INS_SAMPLE_Z;
  endfunction

  // The bit TDO shows next: the instruction register while it is shifted,
  // otherwise the LSB of the data register that the instruction routes.
  function automatic logic sbst_tdo_bit(input sbst_tap_t r, input sbst_path_t p);
    logic b;
    b = r.bypass;
    if (r.st == SBST_SHF_IR) begin
      b = r.ir_shift[0]; // [R5]
    end else begin
      unique case (p)
        SBST_PATH_BSR: begin
          b = r.bsr[0]; // [R5]
        end
        SBST_PATH_ID: begin
          b = r.id[0]; // [R5]
        end
        SBST_PATH_BYP: begin
          b = r.bypass; // [R21]
        end
      endcase
    end
    return b;
  endfunction

  // Decoded from the held instruction, never from the one being shifted in.
  assign path = sbst_path(q.ir); // [R3] [R4]

  always_comb begin
    d = q;
    // Fields not touched below keep their value through the copy, so nothing
    // needs a default of its own.

    // Every input is taken on the rising test-clock edge. [R1]
    if (tck_rise) begin
      d.st = sbst_next(q.st, tms_s); // [R22] [R2] [R7]
    end

    if (tck_rise) begin
      unique case (q.st)
        SBST_CAP_IR: begin
          d.ir_shift = {q.ir[SBST_IR_W-1:2], SBST_IR_CAPTURE}; // [R12]
        end
        SBST_SHF_IR: begin
          d.ir_shift = {tdi_s, q.ir_shift[SBST_IR_W-1:1]}; // [R10] [R5]
        end
        SBST_UPD_IR: begin
          d.ir = q.ir_shift; // [R10]
        end
        default: begin
        end
      endcase
    end
    // Reset state forces the identification code at once, releasing the memory. [R11]
    if (d.st == SBST_TLR) begin
      d.ir = SBST_IR_RESET; // [R11]
    end

    // Exactly one data register moves, chosen by the held instruction. [R3] [R4]
    if (tck_rise) begin
      unique case (q.st)
        SBST_CAP_DR: begin
          // Bypass is cleared on capture so a chain test always reads a known zero first.
          unique case (path)
            SBST_PATH_BSR: begin
              d.bsr = ring_i; // [R16] [R17] [R19]
            end
            SBST_PATH_ID: begin
              d.id = SBST_ID_CODE; // [R18]
            end
            SBST_PATH_BYP: begin
              d.bypass = 1'h0; // [R14]
            end
          endcase
        end
        SBST_SHF_DR: begin
          unique case (path)
            SBST_PATH_BSR: begin
              d.bsr = {tdi_s, q.bsr[SBST_BSR_W-1:1]}; // [R15] [R16] [R5]
            end
            SBST_PATH_ID: begin
              d.id = {tdi_s, q.id[SBST_ID_W-1:1]}; // [R18] [R5]
            end
            SBST_PATH_BYP: begin
              d.bypass = tdi_s; // [R13] [R21]
            end
          endcase
        end
        default: begin
        end
      endcase
    end

    // TDO and its enable move on the falling test-clock edge only. [R1] [R6]
    if (tck_fall) begin
      d.tdo_oe = sbst_is_shift(q.st); // [R6]
      d.tdo = sbst_tdo_bit(q, path); // [R5]
    end

    // Only sample-Z floats the memory; the all-zero code does not. [R20] [R19]
    d.hiz = sbst_floats_memory(q.ir);
    // Test reset is reported but never gates the memory itself. [R8]
    d.trst = (q.st == SBST_TLR);
  end

  // Synchronous reset stands in for the power-up reset of the test logic. [R9] [R11]
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      q <= '{
        st: SBST_TLR,
        ir_shift: SBST_IR_RESET,
        ir: SBST_IR_RESET,
        bypass: 1'h0,
        bsr: '0,
        id: '0,
        tdo: 1'h0,
        tdo_oe: 1'h0,
        hiz: 1'h0,
        trst: 1'h1
      };
    end else if (en_i) begin
      q <= d;
    end
  end

  // Every output leaves straight from a field of the registered record.
  assign tdo_o = q.tdo;
  assign tdo_oe_o = q.tdo_oe;
  assign mem_out_hiz_o = q.hiz;
  assign test_reset_o = q.trst;

endmodule

//--- rtl/sbst_pkg.sv
// Package with constants and types for the SRAM boundary-scan test port.
package sbst_pkg;

  localparam int unsigned SBST_IR_W = 3;
  localparam int unsigned SBST_BSR_W = 107;
  localparam int unsigned SBST_ID_W = 32;
  localparam int unsigned SBST_RESET_TMS_CNT = 5;

  // Instruction codes; the identification code value below is arbitrary.
  localparam logic [2:0] SBST_INS_EXTEST = 3'h0;
  localparam logic [2:0] SBST_INS_IDCODE = 3'h1;
  localparam logic [2:0] SBST_INS_SAMPLE_Z = 3'h2;
  localparam logic [2:0] SBST_INS_SAMPLE = 3'h4;
  localparam logic [2:0] SBST_INS_BYPASS = 3'h7;
  localparam logic [2:0] SBST_IR_RESET = SBST_INS_IDCODE;
  localparam logic [1:0] SBST_IR_CAPTURE = 2'h1;
  localparam logic [31:0] SBST_ID_CODE = 32'h0000_1001;

  typedef enum logic [15:0] {
    SBST_TLR = 16'h0001,
    SBST_RTI = 16'h0002,
    SBST_SEL_DR = 16'h0004,
    SBST_CAP_DR = 16'h0008,
    SBST_SHF_DR = 16'h0010,
    SBST_EX1_DR = 16'h0020,
    SBST_PAU_DR = 16'h0040,
    SBST_EX2_DR = 16'h0080,
    SBST_UPD_DR = 16'h0100,
    SBST_SEL_IR = 16'h0200,
    SBST_CAP_IR = 16'h0400,
    SBST_SHF_IR = 16'h0800,
    SBST_EX1_IR = 16'h1000,
    SBST_PAU_IR = 16'h2000,
    SBST_EX2_IR = 16'h4000,
    SBST_UPD_IR = 16'h8000
  } sbst_state_t;

endpackage

//--- rtl/sbst_sync.sv
// Two-flop synchroniser and edge finder for the test pins.
`timescale 1ns/1ns
module sbst_sync
  import sbst_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic rise_o,
  output logic fall_o,
  output logic tms_o,
  output logic tdi_o
);

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic tck_prev;
  } sbst_sync_t;

  sbst_sync_t q, d;

  always_comb begin
    d = q;
    d.s1 = {tck_i, tms_i, tdi_i};
    d.s2 = q.s1;
    d.tck_prev = q.s2[2];
  end

  // TMS and TDI idle high through their pull-ups and TCK idles low, so reset loads
  // exactly those levels and no false test-clock edge follows the release.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      q <= '{s1: 3'h3, s2: 3'h3, tck_prev: 1'h0};
    end else if (en_i) begin
      q <= d;
    end
  end

  assign rise_o = q.s2[2] & ~q.tck_prev;
  assign fall_o = ~q.s2[2] & q.tck_prev;
  assign tms_o = q.s2[1];
  assign tdi_o = q.s2[0];

endmodule

//--- test/sbst_tap_sva.sv
// Assertions on the pins of the boundary-scan test port.
`timescale 1ns/1ns
module sbst_tap_sva
  import sbst_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic [SBST_BSR_W-1:0] ring_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  input wire logic mem_out_hiz_o,
  input wire logic test_reset_o
);
  // Own two-flop view of the pins, so its rise falls in the same cycle as the design's edge finder while en_i is high.
  logic [2:0] tq;
  logic [1:0] mq;
  logic [2:0] cnt;
  logic lt;
  logic rise;
  assign rise = tq[1] & ~tq[2];
  always_ff @(posedge clk_i) begin
    tq <= {tq[1:0], tck_i};
    mq <= {mq[0], tms_i};
    if (rise) lt <= mq[1];
    if (!nrst_i) cnt <= 3'h0;
    else if (rise) cnt <= mq[1] ? cnt + {2'h0, cnt != 3'h5} : 3'h0;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_rst; $rose(nrst_i) |-> test_reset_o && !tdo_oe_o && !mem_out_hiz_o; endproperty
  property p_five; rise && mq[1] && cnt == 3'h4 |-> ##[1:8] test_reset_o; endproperty
  property p_leave; $fell(test_reset_o) |-> !lt; endproperty
  property p_oe; tdo_oe_o |-> !test_reset_o; endproperty
  property p_hiz; test_reset_o && $past(test_reset_o, 2) |-> !mem_out_hiz_o; endproperty
  property p_hold; rise |=> $stable(tdo_o) [*3]; endproperty
  property p_edge; $changed(tdo_oe_o) |-> !tq[1]; endproperty
  property p_hset; $rose(mem_out_hiz_o) |-> !test_reset_o; endproperty
  a_rst: assert property (p_rst) else $error("bad pins after reset");
  a_five: assert property (p_five) else $error("no reset after five");
  a_leave: assert property (p_leave) else $error("left reset on tms high");
  a_oe: assert property (p_oe) else $error("tdo driven in reset");
  a_hiz: assert property (p_hiz) else $error("hiz kept in reset");
  a_hold: assert property (p_hold) else $error("tdo moved after rise");
  a_edge: assert property (p_edge) else $error("oe moved with tck high");
  a_hset: assert property (p_hset) else $error("hiz set in reset");
  c_five: cover property (rise && mq[1] && cnt == 3'h4);
  c_hiz: cover property ($rose(mem_out_hiz_o));
  c_oe: cover property ($rose(tdo_oe_o));
endmodule
bind sbst_tap sbst_tap_sva i_sva (.clk_i, .nrst_i, .en_i, .tck_i, .tms_i, .tdi_i, .ring_i,
  .tdo_o, .tdo_oe_o, .mem_out_hiz_o, .test_reset_o);

//--- test/sbst_jtag_host.sv
// Model of the board test controller that drives the test pins.
`timescale 1ns/1ns
module sbst_jtag_host (
  input wire logic clk_i,
  input wire logic tdo_i,
  input wire logic tdo_oe_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // Pins move in the low phase; an undriven line reads as the inverse of tdo.
  task automatic step(input logic ms, input logic di, output logic seen);
    tms_o = ms;
    tdi_o = di;
    repeat (4) @(negedge clk_i);
    seen = tdo_oe_i ? tdo_i : !tdo_i;
    tck_o = 1'b1;
    repeat (4) @(negedge clk_i);
    tck_o = 1'b0;
  endtask
  task automatic tap_reset();
    logic s;
    repeat (5) step(1'b1, 1'b1, s);
  endtask
endmodule

//--- test/sbst_tap_bench.sv
// Self-checking bench for the boundary-scan test port.
`timescale 1ns/1ns
module sbst_tap_bench
  import sbst_pkg::*;
;
  logic clk_i, nrst_i, en_i, tck_i, tms_i, tdi_i;
  logic [SBST_BSR_W-1:0] ring_i;
  logic tdo_o, tdo_oe_o, mem_out_hiz_o, test_reset_o;
  int n_fail = 0;
  int checks_done = 0;
  sbst_tap i_dut (.clk_i, .nrst_i, .en_i, .tck_i, .tms_i, .tdi_i, .ring_i, .tdo_o,
    .tdo_oe_o, .mem_out_hiz_o, .test_reset_o);
  sbst_jtag_host i_host (.clk_i, .tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o), .tck_o(tck_i),
    .tms_o(tms_i), .tdi_o(tdi_i));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic walk(input logic [3:0] ms, input int n);
    logic s;
    for (int i = 0; i < n; i++) i_host.step(ms[i], 1'b1, s);
  endtask
  // Scan from idle through one register and back to idle.
  task automatic xfer(input logic ir, input int n, input logic [127:0] din,
    output logic [127:0] dout);
    logic s;
    dout = '0;
    walk(ir ? 4'h3 : 4'h1, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      i_host.step(i == n - 1, din[i], s);
      dout[i] = s;
    end
    walk(4'h1, 2);
  endtask
  task automatic t_id();
    logic [127:0] d;
    xfer(1'b0, 64, 128'hA5C3_0F96, d);
    chk("idcode", d[63:0], {32'hA5C3_0F96, SBST_ID_CODE});
  endtask
  task automatic t_ir(input logic [2:0] code);
    logic [127:0] d;
    xfer(1'b1, 3, {125'h0, code}, d);
    chk("ir capture", d[1:0], SBST_IR_CAPTURE);
  endtask
  task automatic t_bsr(input logic [2:0] code);
    logic [127:0] d;
    ring_i = {2'h2, {35{code}}};
    t_ir(code);
    chk("hiz", mem_out_hiz_o, code == SBST_INS_SAMPLE_Z);
    xfer(1'b0, 108, 128'h1, d);
    chk("ring", d[107:0], {1'b1, ring_i});
  endtask
  task automatic t_byp(input logic [2:0] code);
    logic [127:0] d;
    t_ir(code);
    xfer(1'b0, 8, 128'hB5, d);
    chk("bypass", d[7:0], 8'h6A);
  endtask
  task automatic t_rst();
    t_ir(SBST_INS_SAMPLE_Z);
    walk(4'h1, 3);
    i_host.tap_reset();
    repeat (4) @(negedge clk_i);
    chk("tms reset", {test_reset_o, mem_out_hiz_o, tdo_oe_o}, 3'h4);
    walk(4'h0, 1);
    t_id();
  endtask
  initial begin
    nrst_i = 1'b0;
    en_i = 1'b1;
    ring_i = '0;
    repeat (5) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk("reset pins", {test_reset_o, tdo_oe_o, mem_out_hiz_o}, 3'h4);
    walk(4'h0, 1);
    t_id();
    t_bsr(SBST_INS_EXTEST);
    t_bsr(SBST_INS_SAMPLE);
    t_bsr(SBST_INS_SAMPLE_Z);
    t_byp(SBST_INS_BYPASS);
    t_byp(3'h3);
    t_rst();
    print_verdict();
  end
  initial begin
    #300000;
    n_fail++;
    print_verdict();
  end
endmodule
